/* File: rtl/sra_accum.sv */
// Per-slot offset subtraction, accumulation and averaging of four channels.
`timescale 1ns/100ps
`default_nettype none
module sra_accum
    import sra_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Samples and settings.
    input wire logic valid,
    input wire sra_pkg::sra_chan_t raw,
    input wire sra_pkg::sra_chan_t bias,
    input wire logic [2:0] code,
    // Results.
    output logic [3:0][sra_pkg::SRA_SUM_W-1:0] sum_o,
    output sra_pkg::sra_chan_t avg_o,
    output logic done_o
);

    typedef struct packed {
        logic [6:0] count;
        sra_sum_t acc;
        sra_sum_t sum;
        sra_chan_t avg;
        logic done;
    } sra_acc_state_t;

    sra_acc_state_t s_r;
    sra_acc_state_t s_nxt;
    sra_sum_t acc_add;
    logic [6:0] last;

    assign last = 7'((8'h01 << code) - 8'h01);

    ////////////////////////////////////////////////////////////////////////
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_chan
            logic [15:0] diff;
            // Raw values below the bias clamp to zero instead of wrapping.
            assign diff = (raw[ch] > bias[ch]) ? raw[ch] - bias[ch] : 16'h0000;
            assign acc_add[ch] = s_r.acc[ch] + SRA_SUM_W'(diff);
        end
    endgenerate

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (valid) begin
            // A code lowered mid-group so that last is at or below the count closes the group at the next valid sample.
            if (s_r.count >= last) begin
                s_nxt.sum = acc_add;
                for (int i = 0; i < 4; i++) begin
                    s_nxt.avg[i] = 16'(acc_add[i] >> code);
                end
                s_nxt.acc = '0;
                s_nxt.count = 7'h00;
                s_nxt.done = 1'b1;
            end else begin
                s_nxt.acc = acc_add;
                s_nxt.count = s_r.count + 7'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sum_o = s_r.sum;
    assign avg_o = s_r.avg;
    assign done_o = s_r.done;

    ////////////////////////////////////////////////////////////////////////
    group_close_a: assert property (@(posedge clk) disable iff (!rst_n)
        valid && s_r.count >= last |=> done_o && s_r.count == 7'h00)
        else $error("Group did not close at its last sample.");

    no_early_result_a: assert property (@(posedge clk) disable iff (!rst_n)
        valid && s_r.count < last |=> !done_o && s_r.count == $past(s_r.count) + 7'h01)
        else $error("Result produced before N samples.");

    avg_shift_a: assert property (@(posedge clk) disable iff (!rst_n)
        done_o |-> avg_o[0] == 16'(sum_o[0] >> $past(code)))
        else $error("Average is not the sum shifted by the code.");

    acc_cleared_a: assert property (@(posedge clk) disable iff (!rst_n)
        done_o |-> s_r.acc == '0)
        else $error("Accumulator not cleared after a group.");

    idle_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !valid |=> !done_o && $stable(sum_o) && $stable(avg_o))
        else $error("Results changed without a sample.");

endmodule
`default_nettype wire

/* File: rtl/sra_pkg.sv */
// Package with constants and carrier types of the sample rate, offset and averaging path.
package sra_pkg;

    localparam logic [6:0] SRA_OFS_DIV = 7'h12;
    localparam logic [6:0] SRA_OFS_AVG = 7'h15;
    localparam logic [6:0] SRA_OFS_BIAS_A = 7'h18;
    localparam logic [6:0] SRA_OFS_BIAS_B = 7'h1E;
    localparam logic [6:0] SRA_OFS_FIFO = 7'h60;
    localparam logic [6:0] SRA_OFS_AVG16 = 7'h64;
    localparam logic [6:0] SRA_OFS_SUM = 7'h70;

    localparam logic [15:0] SRA_RST_DIV = 16'h0028;
    localparam logic [15:0] SRA_RST_AVG = 16'h0600;
    localparam logic [15:0] SRA_RST_BIAS = 16'h2000;
    localparam logic [15:0] SRA_AVG_MASK = 16'h0770;

    localparam int SRA_AVG_A_LSB = 4;
    localparam int SRA_AVG_B_LSB = 8;
    localparam logic [17:0] SRA_TICKS_PER_UNIT = 18'h00004;
    localparam logic [1:0] SRA_SRC_TIMER = 2'h0;
    localparam logic [1:0] SRA_SRC_PIN0 = 2'h1;
    localparam logic [1:0] SRA_SRC_PIN1 = 2'h2;

    localparam int SRA_SUM_W = 23;

    typedef logic [3:0][15:0] sra_chan_t;
    typedef logic [3:0][SRA_SUM_W-1:0] sra_sum_t;

    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [15:0] wdata;
    } sra_bus_req_t;

    typedef struct packed {
        logic valid;
        logic slot;
        sra_chan_t raw;
    } sra_adc_t;

endpackage

/* File: rtl/sra_top.sv */
// Register file, sample timing and two slot accumulators.
`timescale 1ns/100ps
`default_nettype none
module sra_top
    import sra_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Register port.
    input wire sra_pkg::sra_bus_req_t bus_req,
    output logic [15:0] reg_rdata,
    // Sample timing.
    input wire logic tick_32k,
    input wire logic [1:0] sample_trigger_source,
    input wire logic ext_trig0,
    input wire logic ext_trig1,
    output logic sample_start,
    // Converter data and result strobes.
    input wire sra_pkg::sra_adc_t adc,
    output logic [1:0] result_valid
);

    typedef struct packed {
        logic [15:0] div;
        logic [15:0] avg_ctl;
        logic [7:0][15:0] bias;
        logic [17:0] cnt;
        logic start;
        logic [15:0] rdata;
        logic [1:0] res_valid;
    } sra_top_state_t;

    sra_top_state_t s_r;
    sra_top_state_t s_nxt;
    logic [1:0] rst_sync_r;
    logic rst_n;
    logic [1:0][2:0] code;
    logic [1:0] done;
    logic [1:0][3:0][SRA_SUM_W-1:0] sum;
    logic [1:0][3:0][15:0] avg;
    logic [17:0] period;
    logic [2:0] avg_idx;

    ////////////////////////////////////////////////////////////////////////
    // The release is synchronised so no flop leaves reset a cycle early.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    assign code[0] = s_r.avg_ctl[SRA_AVG_A_LSB +: 3];
    assign code[1] = s_r.avg_ctl[SRA_AVG_B_LSB +: 3];
    assign period = 18'(s_r.div * SRA_TICKS_PER_UNIT);
    assign avg_idx = 3'(bus_req.addr - SRA_OFS_AVG16);

    ////////////////////////////////////////////////////////////////////////
    genvar sl;
    generate
        for (sl = 0; sl < 2; sl++) begin : g_slot
            sra_accum u_accum (
                .clk(clk),
                .rst_n(rst_n),
                .valid(adc.valid && adc.slot == 1'(sl)),
                .raw(adc.raw),
                .bias(s_r.bias[sl*4 +: 4]),
                .code(code[sl]),
                .sum_o(sum[sl]),
                .avg_o(avg[sl]),
                .done_o(done[sl])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_nxt = s_r;
        s_nxt.start = 1'b0;
        s_nxt.res_valid = done;
        case (sample_trigger_source)
            SRA_SRC_TIMER: begin
                // A zero divider stops the timer rather than firing each tick.
                if (tick_32k && period != 18'h00000) begin
                    if (s_r.cnt + 18'h00001 >= period) begin
                        s_nxt.cnt = 18'h00000;
                        s_nxt.start = 1'b1;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 18'h00001;
                    end
                end
            end
            SRA_SRC_PIN0: s_nxt.start = ext_trig0;
            SRA_SRC_PIN1: s_nxt.start = ext_trig1;
            default: s_nxt.start = 1'b0;
        endcase
        if (bus_req.wr) begin
            case (bus_req.addr)
                SRA_OFS_DIV: s_nxt.div = bus_req.wdata;
                // Reserved bits are not stored, so they read back as zero.
                SRA_OFS_AVG: s_nxt.avg_ctl = bus_req.wdata & SRA_AVG_MASK;
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (bus_req.addr == SRA_OFS_BIAS_A + 7'(i)) begin
                            s_nxt.bias[i] = bus_req.wdata;
                        end
                        if (bus_req.addr == SRA_OFS_BIAS_B + 7'(i)) begin
                            s_nxt.bias[4+i] = bus_req.wdata;
                        end
                    end
                end
            endcase
        end
        s_nxt.rdata = 16'h0000;
        if (bus_req.addr == SRA_OFS_DIV) begin
            s_nxt.rdata = s_r.div;
        end else if (bus_req.addr == SRA_OFS_AVG) begin
            s_nxt.rdata = s_r.avg_ctl;
        end else if (bus_req.addr == SRA_OFS_FIFO) begin
            s_nxt.rdata = avg[0][0];
        end else if (bus_req.addr >= SRA_OFS_AVG16 &&
                     bus_req.addr <= SRA_OFS_AVG16 + 7'h07) begin
            s_nxt.rdata = avg[avg_idx[2]][avg_idx[1:0]];
        end else if (bus_req.addr[6:4] == SRA_OFS_SUM[6:4]) begin
            s_nxt.rdata = bus_req.addr[2]
                ? 16'(sum[bus_req.addr[3]][bus_req.addr[1:0]] >> 16)
                : sum[bus_req.addr[3]][bus_req.addr[1:0]][15:0];
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (bus_req.addr == SRA_OFS_BIAS_A + 7'(i)) begin
                    s_nxt.rdata = s_r.bias[i];
                end
                if (bus_req.addr == SRA_OFS_BIAS_B + 7'(i)) begin
                    s_nxt.rdata = s_r.bias[4+i];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r.div <= SRA_RST_DIV;
            s_r.avg_ctl <= SRA_RST_AVG;
            s_r.bias <= {8{SRA_RST_BIAS}};
            s_r.cnt <= 18'h00000;
            s_r.start <= 1'b0;
            s_r.rdata <= 16'h0000;
            s_r.res_valid <= 2'h0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rdata;
    assign sample_start = s_r.start;
    assign result_valid = s_r.res_valid;

    ////////////////////////////////////////////////////////////////////////
    reset_values_a: assert property (@(posedge clk)
        $rose(rst_n) |-> s_r.div == SRA_RST_DIV && code[1] == 3'h6 &&
            code[0] == 3'h0 && s_r.bias[0] == SRA_RST_BIAS)
        else $error("Configuration left reset with wrong values.");

    timer_period_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.start && $past(sample_trigger_source) == SRA_SRC_TIMER |->
            $past(tick_32k) && $past(s_r.cnt) + 18'h00001 == $past(period))
        else $error("Sample cycle started off the divider period.");

    pin_trigger_a: assert property (@(posedge clk) disable iff (!rst_n)
        sample_trigger_source == SRA_SRC_PIN0 |=> sample_start == $past(ext_trig0))
        else $error("Pin trigger did not start the sample cycle.");

    avg_reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
        bus_req.wr && bus_req.addr == SRA_OFS_AVG |=>
            s_r.avg_ctl == ($past(bus_req.wdata) & SRA_AVG_MASK))
        else $error("Averaging control stored reserved bits.");

    result_strobe_a: assert property (@(posedge clk) disable iff (!rst_n)
        done[1] |=> result_valid[1] ##1 (!result_valid[1] || $past(done[1])))
        else $error("Result strobe did not follow the group end.");

    no_source_a: assert property (@(posedge clk) disable iff (!rst_n)
        sample_trigger_source == 2'h3 |=> !sample_start)
        else $error("Sample cycle started with no trigger source.");

    zero_divider_a: assert property (@(posedge clk) disable iff (!rst_n)
        sample_trigger_source == SRA_SRC_TIMER && period == 18'h00000 |=>
            !sample_start)
        else $error("Sample cycle started with a zero divider.");

    pin1_trigger_a: assert property (@(posedge clk) disable iff (!rst_n)
        sample_trigger_source == SRA_SRC_PIN1 |=>
            sample_start == $past(ext_trig1))
        else $error("Second pin trigger did not start the sample cycle.");

    div_readback_a: assert property (@(posedge clk) disable iff (!rst_n)
        bus_req.addr == SRA_OFS_DIV |=> reg_rdata == $past(s_r.div))
        else $error("Divider read back a wrong value.");

    fifo_mirror_a: assert property (@(posedge clk) disable iff (!rst_n)
        bus_req.addr == SRA_OFS_FIFO |=> reg_rdata == $past(avg[0][0]))
        else $error("Read location does not show the first average.");

endmodule
`default_nettype wire

/* File: verification/sra_tb.sv */
// Self-checking bench of the sample timing, bias and averaging path.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import sra_pkg::*;
    logic clk;
    logic reset_n;
    sra_bus_req_t bus_req;
    logic [15:0] reg_rdata;
    logic tick_32k;
    logic [1:0] sample_trigger_source;
    logic ext_trig0;
    logic ext_trig1;
    logic sample_start;
    sra_adc_t adc;
    logic [1:0] result_valid;
    int num_errors;
    int samples_checked;

    sra_top dut_u (.clk(clk), .reset_n(reset_n), .bus_req(bus_req),
        .reg_rdata(reg_rdata), .tick_32k(tick_32k),
        .sample_trigger_source(sample_trigger_source),
        .ext_trig0(ext_trig0), .ext_trig1(ext_trig1),
        .sample_start(sample_start), .adc(adc),
        .result_valid(result_valid));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Inputs move 1 ns after the edge so no race with the sampling edge.
    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [6:0] a, input logic [15:0] d);
        bus_req = '{wr: 1'b1, addr: a, wdata: d};
        step();
        bus_req.wr = 1'b0;
        step();
    endtask

    task automatic reg_read(input logic [6:0] a, input logic [15:0] exp);
        bus_req.addr = a;
        step();
        check($sformatf("register %h", a), exp, reg_rdata);
    endtask

    // Pulses one trigger input and counts starts over the next three cycles.
    task automatic pulse(input int sel, inout int starts);
        tick_32k = (sel == 0);
        ext_trig0 = (sel == 1);
        ext_trig1 = (sel == 2);
        step();
        tick_32k = 1'b0;
        ext_trig0 = 1'b0;
        ext_trig1 = 1'b0;
        repeat (3) begin
            starts += (sample_start === 1'b1);
            step();
        end
    endtask

    // Sends one sample and counts result strobes of its slot for a while.
    task automatic send(input logic s, input sra_chan_t r, input int cyc,
                        inout int res);
        adc = '{valid: 1'b1, slot: s, raw: r};
        step();
        adc.valid = 1'b0;
        repeat (cyc) begin
            res += (result_valid[s] === 1'b1);
            step();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_defaults();
        reg_read(7'h12, 16'h0028);
        reg_read(7'h15, 16'h0600);
        reg_read(7'h18, 16'h2000);
        for (int i = 0; i < 4; i++) begin
            reg_read(7'h19 + 7'(i), (i < 3) ? 16'h2000 : 16'h0000);
            reg_read(7'h1E + 7'(i), 16'h2000);
        end
        reg_write(7'h15, 16'h0770);
        reg_read(7'h15, 16'h0770);
    endtask

    task automatic test_timing();
        int st;
        st = 0;
        reg_write(7'h12, 16'h0002);
        repeat (7) pulse(0, st);
        check("starts before count", 16'h0000, 16'(st));
        pulse(0, st);
        check("starts at count", 16'h0001, 16'(st));
        sample_trigger_source = 2'h1;
        repeat (8) pulse(0, st);
        pulse(2, st);
        check("starts with pin source", 16'h0001, 16'(st));
        pulse(1, st);
        check("starts on pin 0", 16'h0002, 16'(st));
        sample_trigger_source = 2'h2;
        pulse(2, st);
        check("starts on pin 1", 16'h0003, 16'(st));
        sample_trigger_source = 2'h3;
        for (int k = 0; k < 3; k++) pulse(k, st);
        check("starts with no source", 16'h0003, 16'(st));
        sample_trigger_source = 2'h0;
        reg_write(7'h12, 16'h0000);
        repeat (9) pulse(0, st);
        check("starts with zero divider", 16'h0003, 16'(st));
    endtask

    task automatic test_slot_a();
        logic [15:0] s[4] = '{16'h0008, 16'h0016, 16'h0001, 16'h0200};
        logic [15:0] v[4] = '{16'h0004, 16'h000B, 16'h0000, 16'h0100};
        int res;
        res = 0;
        reg_write(7'h15, 16'h0010);
        reg_write(7'h19, 16'h1000);
        send(1'b0, {16'h2100, 16'h1FFF, 16'h1010, 16'h2005}, 4, res);
        check("slot A early results", 16'h0000, 16'(res));
        send(1'b0, {16'h2100, 16'h2001, 16'h1006, 16'h2003}, 4, res);
        check("slot A results", 16'h0001, 16'(res));
        for (int c = 0; c < 4; c++) begin
            reg_read(7'h70 + 7'(c), s[c]);
            reg_read(7'h74 + 7'(c), 16'h0000);
            reg_read(7'h64 + 7'(c), v[c]);
        end
        reg_read(7'h60, 16'h0004);
    endtask

    // Code 7 is used so the sums of channels 0 and 1 outgrow 16 bits and fill the high words.
    task automatic test_slot_b();
        logic [15:0] lo[4] = '{16'h0000, 16'hFF80, 16'h0000, 16'h0080};
        logic [15:0] hi[4] = '{16'h0008, 16'h007F, 16'h0000, 16'h0000};
        logic [15:0] v[4] = '{16'h1000, 16'hFFFF, 16'h0000, 16'h0001};
        int res;
        res = 0;
        reg_write(7'h15, 16'h0700);
        reg_write(7'h1F, 16'h0000);
        repeat (127) send(1'b1, {16'h2001, 16'h2000, 16'hFFFF, 16'h3000},
                          1, res);
        check("slot B early results", 16'h0000, 16'(res));
        send(1'b1, {16'h2001, 16'h2000, 16'hFFFF, 16'h3000}, 4, res);
        check("slot B results", 16'h0001, 16'(res));
        for (int c = 0; c < 4; c++) begin
            reg_read(7'h78 + 7'(c), lo[c]);
            reg_read(7'h7C + 7'(c), hi[c]);
            reg_read(7'h68 + 7'(c), v[c]);
        end
        res = 0;
        send(1'b0, {16'h2000, 16'h2000, 16'h1000, 16'h2009}, 4, res);
        check("slot A single result", 16'h0001, 16'(res));
        reg_read(7'h70, 16'h0009);
        reg_read(7'h64, 16'h0009);
    endtask

    // A reset in mid-run must bring back every default and drop old results.
    task automatic test_reset();
        reset_n = 1'b0;
        step();
        check("read data in reset", 16'h0000, reg_rdata);
        check("strobes in reset", 16'h0000, {14'h0000, result_valid});
        repeat (2) step();
        reset_n = 1'b1;
        repeat (4) step();
        reg_read(7'h12, 16'h0028);
        reg_read(7'h15, 16'h0600);
        reg_read(7'h19, 16'h2000);
        reg_read(7'h70, 16'h0000);
        reg_read(7'h64, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        num_errors = 0;
        samples_checked = 0;
        reset_n = 1'b0;
        bus_req = '0;
        tick_32k = 1'b0;
        sample_trigger_source = 2'h0;
        ext_trig0 = 1'b0;
        ext_trig1 = 1'b0;
        adc = '0;
        repeat (3) @(posedge clk);
        #1;
        reset_n = 1'b1;
        repeat (4) step();
        test_defaults();
        test_timing();
        test_slot_a();
        test_slot_b();
        test_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
